// [inc/shutdown_pkg.sv]
package shutdown_pkg;

	// ==========================================================
	// Widths
	localparam int CNT_W      = 6;
	localparam int FAULT_N    = 8;
	localparam int DIVIDE_BY  = 4;
	localparam int DIV_W      = 2;

	// ==========================================================
	// Fault source positions
	localparam int FLT_PIN    = 0;
	localparam int FLT_CMP1   = 1;
	localparam int FLT_CMP4   = 4;
	localparam int FLT_CELL   = 5;
	localparam int FLT_TMR_A  = 6;
	localparam int FLT_TMR_B  = 7;

	// ==========================================================
	// Override level codes
	localparam logic [1:0] OVR_INACTIVE = 2'h0;
	localparam logic [1:0] OVR_TRISTATE = 2'h1;
	localparam logic [1:0] OVR_LOW      = 2'h2;
	localparam logic [1:0] OVR_HIGH     = 2'h3;

	// ==========================================================
	// Clock select codes
	localparam logic [1:0] CLK_SYS_DIV4 = 2'h0;
	localparam logic [1:0] CLK_SYS      = 2'h1;
	localparam logic [1:0] CLK_HFOSC    = 2'h2;

	// ==========================================================
	// Reset and divider wrap values
	localparam logic [CNT_W-1:0] CNT_RESET = 6'h00;
	localparam logic [DIV_W-1:0] DIV_LAST  = 2'h3;

	// ==========================================================
	// Types
	typedef struct packed {
		logic [CNT_W-1:0] rise_phase;
		logic [CNT_W-1:0] fall_phase;
		logic [CNT_W-1:0] rise_dead;
		logic [CNT_W-1:0] fall_dead;
		logic [CNT_W-1:0] rise_blank;
		logic [CNT_W-1:0] fall_blank;
	} counts_t;

	typedef struct packed {
		logic [3:0] level;
		logic [3:0] enable;
	} drive_t;

	typedef enum logic [1:0] {
		ST_SHUTDOWN,
		ST_WAIT_RISE,
		ST_RUN
	} sd_state_t;

endpackage

// [logic/shutdown_ctrl.sv]
// Contract
// - Count values are only buffered; no delay is timed
// - Overrides hold until first rise after clear
// - Software set flag forces immediate shutdown
// - No auto restart: wait software clear
// - Active fault resets drive latches at once
// - Enabled fault active while low
// - Eight fault sources, each own enable
// - Fault level blocks clearing unless disabled
// - One 2-bit override field per output pair
// - Polarity affects normal levels and inactive override
// - One bit chooses restart method
// - Software clear refused while fault active
// - Auto restart clears flag when faults idle
// - Disabled: count writes load buffers directly
// - Enabled: load request moves all, self-clears
// - Pin input: rise, fall and fault source
// - Keeps running in sleep with clock
// - Oscillator kept on in sleep when selected
// - Block enables its own output drivers
// - Clock select: div4, system, oscillator
module shutdown_ctrl
	import shutdown_pkg::*;
(
	// Clock and reset
	input  wire logic                   mclk_i,
	input  wire logic                   reset_i,
	// Configuration
	input  wire logic                   enable_i,
	input  wire logic [1:0]             clock_select_i,
	input  wire logic [3:0]             polarity_i,
	input  wire logic [1:0]             override_level_pair_ac_i,
	input  wire logic [1:0]             override_level_pair_bd_i,
	input  wire logic                   auto_restart_enable_i,
	input  wire logic [FAULT_N-1:0]     fault_source_select_i,
	input  wire logic                   sleep_i,
	// Shutdown flag access
	input  wire logic                   flag_set_i,
	input  wire logic                   flag_clear_i,
	output logic                        shutdown_active_flag_o,
	// Count registers
	input  wire logic                   count_write_i,
	input  shutdown_pkg::counts_t       count_wdata_i,
	input  wire logic                   load_request_set_i,
	output logic                        buffer_load_request_o,
	output shutdown_pkg::counts_t       count_buffer_o,
	// Event and fault inputs
	input  wire logic                   input_pin_i,
	input  wire logic                   rise_sel_pin_i,
	input  wire logic                   fall_sel_pin_i,
	input  wire logic                   rise_other_i,
	input  wire logic                   fall_other_i,
	input  wire logic [3:0]             comparator_i,
	input  wire logic                   logic_cell_i,
	input  wire logic [1:0]             timer_i,
	// Outputs
	output shutdown_pkg::drive_t        drive_o,
	output logic                        keep_osc_on_o,
	output logic                        gen_tick_o
);

	// ==========================================================
	// Input synchronisers
	logic [FAULT_N-1:0] fault_raw;
	logic [FAULT_N-1:0] fault_sync;
	assign fault_raw = {timer_i, logic_cell_i, comparator_i, input_pin_i};

	genvar gi;
	generate
		for (gi = 0; gi < FAULT_N; gi++) begin : g_sync
			sync3 u_sync (
				.mclk_i  (mclk_i),
				.reset_i (reset_i),
				.async_i (fault_raw[gi]),
				.level_o (fault_sync[gi])
			);
		end
	endgenerate

	// Pin fault and rising/falling events share the synchronised pin
	logic pin_sync;
	assign pin_sync = fault_sync[FLT_PIN];

	// ==========================================================
	// Generator clock enable
	logic [DIV_W-1:0] div_q;
	logic [DIV_W-1:0] div_d;
	logic             div_tick;
	assign div_tick = (div_q == DIV_LAST);
	assign div_d    = div_tick ? '0 : div_q + DIV_W'(1);

	always_ff @(posedge mclk_i) begin
		if (reset_i) begin
			div_q <= '0;
		end else begin
			div_q <= div_d;
		end
	end

	logic tick;
	assign tick = (clock_select_i == CLK_SYS_DIV4) ? div_tick :
	              (clock_select_i == CLK_SYS)      ? 1'b1 :
	              (clock_select_i == CLK_HFOSC)    ? 1'b1 :
	              1'b0;
	assign gen_tick_o = tick & enable_i;

	// Oscillator request held through sleep when chosen
	assign keep_osc_on_o = enable_i &
	                       (clock_select_i == CLK_HFOSC);

	// ==========================================================
	// Event detection
	logic rise_level;
	logic fall_level;
	logic rise_prev_q;
	logic fall_prev_q;
	logic rise_evt;
	logic fall_evt;
	assign rise_level = (rise_sel_pin_i & pin_sync) | rise_other_i;
	assign fall_level = (fall_sel_pin_i & pin_sync) | fall_other_i;

	always_ff @(posedge mclk_i) begin
		if (reset_i) begin
			rise_prev_q <= 1'b0;
			fall_prev_q <= 1'b0;
		end else if (gen_tick_o) begin
			rise_prev_q <= rise_level;
			fall_prev_q <= fall_level;
		end
	end

	// Sampled on the generator tick, so timing is within one period
	assign rise_evt = gen_tick_o & rise_level & ~rise_prev_q;
	assign fall_evt = gen_tick_o & fall_level & ~fall_prev_q;

	// ==========================================================
	// Fault decode
	logic fault_active;
	// Enabled source counts while its level is low
	assign fault_active = |(fault_source_select_i & ~fault_sync);

	// ==========================================================
	// Shutdown flag and state
	sd_state_t state_q;
	sd_state_t state_d;
	logic      flag_q;
	logic      flag_d;

	always_comb begin
		flag_d = flag_q;
		if (flag_clear_i && !auto_restart_enable_i) begin
			flag_d = 1'b0;
		end
		if (auto_restart_enable_i && !fault_active) begin
			flag_d = 1'b0;
		end
		if (flag_set_i) begin
			flag_d = 1'b1;
		end
		if (fault_active) begin
			flag_d = 1'b1;
		end
	end

	always_comb begin
		state_d = state_q;
		case (state_q)
			ST_RUN: begin
				if (flag_d) begin
					state_d = ST_SHUTDOWN;
				end
			end
			ST_SHUTDOWN: begin
				if (!flag_d) begin
					state_d = ST_WAIT_RISE;
				end
			end
			ST_WAIT_RISE: begin
				if (flag_d) begin
					state_d = ST_SHUTDOWN;
				end else if (rise_evt) begin
					state_d = ST_RUN;
				end
			end
			default: begin
				state_d = ST_SHUTDOWN;
			end
		endcase
	end

	always_ff @(posedge mclk_i) begin
		if (reset_i) begin
			flag_q  <= 1'b0;
			state_q <= ST_SHUTDOWN;
		end else begin
			flag_q  <= flag_d;
			state_q <= state_d;
		end
	end

	assign shutdown_active_flag_o = flag_q;

	// Overrides apply combinationally the moment a fault appears
	logic overriding;
	assign overriding = (state_q != ST_RUN) | flag_set_i | fault_active;

	// ==========================================================
	// Drive latches
	logic drive_q;
	always_ff @(posedge mclk_i) begin
		if (reset_i) begin
			drive_q <= 1'b0;
		end else if (overriding || !enable_i) begin
			drive_q <= 1'b0;
		end else if (fall_evt) begin
			drive_q <= 1'b0;
		end else if (rise_evt) begin
			drive_q <= 1'b1;
		end
	end

	// ==========================================================
	// Output levels
	logic [3:0] active_vec;
	logic [3:0] normal_lvl;
	logic [3:0] inactive_lvl;
	logic [1:0] ovr_code [4];
	drive_t     drive_d;

	// Outputs A and C primary, B and D complementary
	assign active_vec   = {~drive_q, drive_q, ~drive_q, drive_q};
	assign normal_lvl   = active_vec ^ polarity_i;
	assign inactive_lvl = polarity_i;
	assign ovr_code[0]  = override_level_pair_ac_i;
	assign ovr_code[2]  = override_level_pair_ac_i;
	assign ovr_code[1]  = override_level_pair_bd_i;
	assign ovr_code[3]  = override_level_pair_bd_i;

	always_comb begin
		drive_d = '0;
		for (int i = 0; i < 4; i++) begin
			if (!enable_i) begin
				drive_d.level[i]  = 1'b0;
				drive_d.enable[i] = 1'b1;
			end else if (overriding) begin
				// Enable is active low: low while driving
				drive_d.enable[i] = 1'b0;
				case (ovr_code[i])
					OVR_LOW: begin
						drive_d.level[i] = 1'b0;
					end
					OVR_HIGH: begin
						drive_d.level[i] = 1'b1;
					end
					OVR_TRISTATE: begin
						drive_d.level[i]  = 1'b0;
						drive_d.enable[i] = 1'b1;
					end
					default: begin
						drive_d.level[i] = inactive_lvl[i];
					end
				endcase
			end else begin
				drive_d.level[i]  = normal_lvl[i];
				drive_d.enable[i] = 1'b0;
			end
		end
	end

	assign drive_o = drive_d;

	// ==========================================================
	// Count double buffering
	counts_t pend_q;
	counts_t buf_q;
	logic    load_q;

	always_ff @(posedge mclk_i) begin
		if (reset_i) begin
			pend_q <= '0;
		end else if (count_write_i) begin
			pend_q <= count_wdata_i;
		end
	end

	always_ff @(posedge mclk_i) begin
		if (reset_i) begin
			buf_q <= '0;
		end else if (!enable_i && count_write_i) begin
			buf_q <= count_wdata_i;
		end else if (enable_i && load_q && rise_evt) begin
			buf_q <= pend_q;
		end
	end

	// Request set by software wins over the hardware clear
	always_ff @(posedge mclk_i) begin
		if (reset_i) begin
			load_q <= 1'b0;
		end else if (load_request_set_i) begin
			load_q <= 1'b1;
		end else if (!enable_i || rise_evt) begin
			load_q <= 1'b0;
		end
	end

	assign buffer_load_request_o = load_q;
	assign count_buffer_o        = buf_q;

endmodule

// [logic/sync3.sv]
module sync3 (
	input  wire logic mclk_i,
	input  wire logic reset_i,
	input  wire logic async_i,
	output logic      level_o
);
	logic s1_q;
	logic s2_q;
	logic s3_q;

	// ==========================================================
	// Three stages; change taken when stages two and three agree
	always_ff @(posedge mclk_i) begin
		if (reset_i) begin
			s1_q    <= 1'b1;
			s2_q    <= 1'b1;
			s3_q    <= 1'b1;
			level_o <= 1'b1;
		end else begin
			s1_q <= async_i;
			s2_q <= s1_q;
			s3_q <= s2_q;
			if (s2_q == s3_q) begin
				level_o <= s3_q;
			end
		end
	end
endmodule

// [verif/fault_sources.sv]
module fault_sources #(
	parameter int DLY = 3
) (
	input  wire logic [7:0] fault_req_i,
	output logic            input_pin_o,
	output logic [3:0]      comparator_o,
	output logic            logic_cell_o,
	output logic [1:0]      timer_o
);
	timeunit 1ns;
	timeprecision 1ns;

	// ==========================================================
	// Sources idle high and pull low off the clock edge
	initial {timer_o, logic_cell_o, comparator_o, input_pin_o} = 8'hff;
	always @(fault_req_i)
		{timer_o, logic_cell_o, comparator_o, input_pin_o} <= #DLY ~fault_req_i;
endmodule

// [verif/shutdown_ctrl_monitor.sv]
module shutdown_ctrl_monitor
	import shutdown_pkg::*;
(
	// Clock and configuration
	input  wire logic                   mclk_i,
	input  wire logic                   reset_i,
	input  wire logic                   enable_i,
	input  wire logic [1:0]             clock_select_i,
	input  wire logic [3:0]             polarity_i,
	input  wire logic [1:0]             override_level_pair_ac_i,
	input  wire logic                   auto_restart_enable_i,
	input  wire logic [FAULT_N-1:0]     fault_source_select_i,
	input  wire logic                   flag_set_i,
	input  wire logic                   count_write_i,
	input  shutdown_pkg::counts_t       count_wdata_i,
	// Fault lines
	input  wire logic                   input_pin_i,
	input  wire logic [3:0]             comparator_i,
	input  wire logic                   logic_cell_i,
	input  wire logic [1:0]             timer_i,
	// Watched outputs
	input  wire logic                   shutdown_active_flag_o,
	input  wire logic                   buffer_load_request_o,
	input  shutdown_pkg::counts_t       count_buffer_o,
	input  shutdown_pkg::drive_t        drive_o,
	input  wire logic                   keep_osc_on_o,
	input  wire logic                   gen_tick_o
);
	timeunit 1ns;
	timeprecision 1ns;

	default clocking @(posedge mclk_i);
	endclocking
	default disable iff (reset_i);

	// ==========================================================
	// Helper logic
	wire logic [7:0] raw_w = {timer_i, logic_cell_i, comparator_i, input_pin_i};
	wire logic       idle_w = (fault_source_select_i & ~raw_w) == 8'h00;
	counts_t         pend_q;

	always_ff @(posedge mclk_i)
		if (count_write_i)
			pend_q <= count_wdata_i;

	// ==========================================================
	// Assertions
	flag_set_a: assert property (flag_set_i |=> shutdown_active_flag_o)
		else $error("flag not set by software");
	force_high_a: assert property (
		shutdown_active_flag_o && enable_i && override_level_pair_ac_i == OVR_HIGH
		|-> drive_o.level[0] && drive_o.level[2] && !drive_o.enable[0])
		else $error("forced high override wrong");
	tristate_ovr_a: assert property (
		shutdown_active_flag_o && enable_i
		&& override_level_pair_ac_i == OVR_TRISTATE
		|-> drive_o.enable[0] && drive_o.enable[2])
		else $error("tristate override wrong");
	inactive_ovr_a: assert property (
		shutdown_active_flag_o && enable_i
		&& override_level_pair_ac_i == OVR_INACTIVE
		|-> drive_o.level[0] == polarity_i[0] && !drive_o.enable[0])
		else $error("inactive override ignores polarity");
	fault_flag_a: assert property (
		(fault_source_select_i[FLT_CMP1] && !comparator_i[0])[*6]
		|=> shutdown_active_flag_o)
		else $error("fault did not set flag");
	fault_ovr_a: assert property (
		(enable_i && fault_source_select_i[FLT_PIN] && !input_pin_i
		&& override_level_pair_ac_i == OVR_TRISTATE)[*6]
		|-> drive_o.enable[0] && drive_o.enable[2])
		else $error("fault did not force override");
	auto_clear_a: assert property (
		(auto_restart_enable_i && idle_w && !flag_set_i)[*6]
		|-> !shutdown_active_flag_o)
		else $error("auto restart kept flag");
	direct_load_a: assert property (
		!enable_i && count_write_i |=> count_buffer_o == $past(count_wdata_i))
		else $error("disabled write not loaded");
	load_done_a: assert property (
		$fell(buffer_load_request_o) |-> count_buffer_o == pend_q)
		else $error("load request cleared without transfer");
	keep_osc_a: assert property (
		keep_osc_on_o == (enable_i && clock_select_i == CLK_HFOSC))
		else $error("oscillator keep-on wrong");
	sys_tick_a: assert property (
		(enable_i && clock_select_i == CLK_SYS)[*2] |-> gen_tick_o)
		else $error("system clock tick missing");
endmodule

bind shutdown_ctrl shutdown_ctrl_monitor mon_u (.mclk_i, .reset_i, .enable_i,
	.clock_select_i, .polarity_i, .override_level_pair_ac_i,
	.auto_restart_enable_i, .fault_source_select_i, .flag_set_i,
	.count_write_i, .count_wdata_i, .input_pin_i, .comparator_i,
	.logic_cell_i, .timer_i, .shutdown_active_flag_o, .buffer_load_request_o,
	.count_buffer_o, .drive_o, .keep_osc_on_o, .gen_tick_o);

// [verif/tb_shutdown_ctrl.sv]
module tb_shutdown_ctrl
	import shutdown_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;

	localparam counts_t C1 = 36'h123456789;
	localparam counts_t C2 = 36'h9abcdef01;
	logic        mclk_i = 1'b0;
	logic        reset_i = 1'b1;
	logic        enable_i, auto_restart_enable_i, sleep_i, flag_set_i;
	logic        flag_clear_i, count_write_i, load_request_set_i, rise_other_i;
	logic        input_pin_i, logic_cell_i, shutdown_active_flag_o;
	logic        buffer_load_request_o, keep_osc_on_o;
	logic        gen_tick_o, rise_sel_pin_i;
	logic [1:0]  clock_select_i, override_level_pair_ac_i, timer_i;
	logic [1:0]  override_level_pair_bd_i;
	logic [3:0]  polarity_i, comparator_i;
	logic [7:0]  fault_source_select_i, fault_req;
	counts_t     count_wdata_i, count_buffer_o;
	drive_t      drive_o;
	int          error_cnt = 0;
	int          check_count = 0;

	always #5 mclk_i = ~mclk_i;

	shutdown_ctrl dut_u (.mclk_i, .reset_i, .enable_i, .clock_select_i,
		.polarity_i, .override_level_pair_ac_i, .override_level_pair_bd_i,
		.auto_restart_enable_i, .fault_source_select_i, .sleep_i,
		.flag_set_i, .flag_clear_i, .shutdown_active_flag_o, .count_write_i,
		.count_wdata_i, .load_request_set_i, .buffer_load_request_o,
		.count_buffer_o, .input_pin_i, .rise_sel_pin_i,
		.fall_sel_pin_i(1'b0), .rise_other_i, .fall_other_i(1'b0),
		.comparator_i, .logic_cell_i, .timer_i, .drive_o, .keep_osc_on_o,
		.gen_tick_o);
	fault_sources #(.DLY(3)) src_u (.fault_req_i(fault_req),
		.input_pin_o(input_pin_i), .comparator_o(comparator_i),
		.logic_cell_o(logic_cell_i), .timer_o(timer_i));

	// ==========================================================
	// Tasks
	task automatic cyc(int n);
		repeat (n) @(posedge mclk_i);
	endtask
	localparam int P_WR   = 0;
	localparam int P_SET  = 1;
	localparam int P_CLR  = 2;
	localparam int P_LD   = 3;
	localparam int P_RISE = 4;
	task automatic strobe(int s, logic v);
		case (s)
			P_WR:    count_write_i <= v;
			P_SET:   flag_set_i <= v;
			P_CLR:   flag_clear_i <= v;
			P_LD:    load_request_set_i <= v;
			default: rise_other_i <= v;
		endcase
	endtask
	task automatic pulse(int s);
		cyc(1);
		strobe(s, 1'b1);
		cyc(1);
		strobe(s, 1'b0);
	endtask
	task automatic complete_run();
		$display("checks %0d mismatches %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic chk(string nm, logic [35:0] seen, logic [35:0] exp);
		check_count++;
		if (seen !== exp) begin
			error_cnt++;
			$display("FAIL %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	function automatic logic obs(int s);
		return s == 0 ? shutdown_active_flag_o :
			s == 1 ? buffer_load_request_o : drive_o.enable[0];
	endfunction
	task automatic wait_for(int s, logic v, string nm);
		// Step off the edge so settled outputs are seen
		#2;
		for (int k = 0; k < 40 && obs(s) !== v; k++) begin
			cyc(1);
			#2;
		end
		chk(nm, obs(s), v);
		if (obs(s) !== v)
			complete_run();
	endtask

	// ==========================================================
	// Main sequence
	initial begin
		logic [1:0] code;
		logic       lv;
		int         ticks;
		{enable_i, auto_restart_enable_i, sleep_i, flag_set_i} = 4'h0;
		rise_sel_pin_i = 1'b0;
		{flag_clear_i, count_write_i, load_request_set_i, rise_other_i} = 4'h0;
		{clock_select_i, override_level_pair_ac_i} = {CLK_SYS, OVR_LOW};
		override_level_pair_bd_i = OVR_LOW;
		polarity_i = 4'h0;
		{fault_source_select_i, fault_req} = 16'h0000;
		count_wdata_i = C1;
		cyc(20);
		reset_i <= 1'b0;
		pulse(P_WR);
		#2 chk("direct", count_buffer_o, C1);
		pulse(P_SET);
		#2 chk("flag set", shutdown_active_flag_o, 1'b1);
		cyc(1);
		enable_i <= 1'b1;
		for (int c = 0; c < 5; c++) begin
			code = c[1:0];
			lv = code == OVR_HIGH || (code == OVR_INACTIVE && c < 4);
			cyc(1);
			override_level_pair_ac_i <= code;
			polarity_i <= (c < 4) ? 4'hf : 4'h0;
			#2 chk("ovr en", drive_o.enable[0], code == OVR_TRISTATE);
			if (code != OVR_TRISTATE)
				chk("ovr lvl", {drive_o.level[0], drive_o.level[2]}, {2{lv}});
		end
		$display("override test done");
		cyc(1);
		override_level_pair_ac_i <= OVR_TRISTATE;
		pulse(P_CLR);
		#2 chk("flag clr", shutdown_active_flag_o, 1'b0);
		cyc(5);
		#2 chk("hold ovr", drive_o.enable[0], 1'b1);
		pulse(P_RISE);
		wait_for(2, 1'b0, "resume");
		cyc(1);
		count_wdata_i <= C2;
		pulse(P_WR);
		#2 chk("held", count_buffer_o, C1);
		pulse(P_LD);
		#2 chk("ld set", buffer_load_request_o, 1'b1);
		cyc(3);
		#2 chk("ld wait", count_buffer_o, C1);
		pulse(P_RISE);
		wait_for(1, 1'b0, "ld clr");
		chk("ld buf", count_buffer_o, C2);
		$display("restart and load test done");
		cyc(1);
		fault_req <= 8'hff;
		cyc(6);
		#2 chk("unsel", shutdown_active_flag_o, 1'b0);
		for (int i = 0; i < 8; i++) begin
			cyc(1);
			fault_source_select_i <= 8'h01 << i;
			cyc(6);
			#2 chk("flt flag", shutdown_active_flag_o, 1'b1);
			chk("flt ovr", drive_o.enable[0], 1'b1);
			pulse(P_CLR);
			#2 chk("clr refused", shutdown_active_flag_o, 1'b1);
			cyc(1);
			fault_source_select_i <= 8'h00;
			pulse(P_CLR);
			#2 chk("clr ok", shutdown_active_flag_o, 1'b0);
		end
		$display("fault test done");
		cyc(1);
		{sleep_i, auto_restart_enable_i} <= 2'h3;
		fault_source_select_i <= 8'h01;
		cyc(6);
		#2 chk("auto hold", shutdown_active_flag_o, 1'b1);
		cyc(1);
		fault_req <= 8'h00;
		wait_for(0, 1'b0, "auto clr");
		for (int s = 0; s < 4; s++) begin
			cyc(1);
			clock_select_i <= s[1:0];
			#2 chk("osc", keep_osc_on_o, s == 2);
			ticks = 0;
			repeat (8) begin
				cyc(1);
				#2 ticks += gen_tick_o;
			end
			chk("ticks", ticks, (s == 0) ? 8 / DIVIDE_BY : (s == 3) ? 0 : 8);
		end
		// Pin used as the rising event source
		cyc(1);
		clock_select_i <= CLK_SYS;
		fault_source_select_i <= 8'h00;
		fault_req <= 8'h01;
		cyc(6);
		rise_sel_pin_i <= 1'b1;
		cyc(6);
		#2 chk("pin hold", drive_o.enable[0], 1'b1);
		cyc(1);
		fault_req <= 8'h00;
		wait_for(2, 1'b0, "pin rise");
		$display("auto restart test done");
		complete_run();
	end
endmodule
